// File: test_tpio_pin_io.sv
// Self-checking bench for the timing controller pin block.
`timescale 1ns/100ps
module test_tpio_pin_io;
  import tpio_pkg::*;
  // Clock, reset and external pins.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_PINS-1:0] sourcePins = '0;
  logic [NUM_PINS-1:0] gatePins = '0;
  // Host strobes and line levels.
  logic csN, rdN, wrN, controlSel;
  logic [DATA_W-1:0] hostLevel, busLine, hostDataOut, hostDataOe_n;
  // Counter configuration, all counters idle at start.
  logic [NUM_CTR-1:0][SEL_W-1:0] ctrSrcSel = {NUM_CTR{SEL_NONE}};
  logic [NUM_CTR-1:0] ctrSrcPol = '0;
  logic [NUM_CTR-1:0][GSEL_W-1:0] ctrGateSel = '0;
  logic [NUM_CTR-1:0] ctrGatePol = '0;
  tpio_gate_mode_type [NUM_CTR-1:0] ctrGateMode;
  tpio_out_mode_type [NUM_CTR-1:0] ctrOutMode;
  logic [NUM_CTR-1:0] ctrOutPol = 5'h15;
  logic [NUM_CTR-1:0][CNT_W-1:0] ctrLoad = '0;
  logic [NUM_CTR-1:0][CNT_W-1:0] ctrHold = '0;
  logic [1:0] alarmEnable = 2'h0;
  logic [1:0][CNT_W-1:0] alarmValue = '0;
  // Observed outputs.
  logic [NUM_CTR-1:0] counterOutputs, counterOutputsOe_n;
  logic freqOut, busWide;
  logic [PTR_W-1:0] dataPointer;
  logic [BYTE_W-1:0] commandCode;
  // Bench bookkeeping.
  int nErrors = 0;
  int numChecks = 0;
  int foutCnt;
  int outCnt [NUM_CTR];
  logic [DATA_W-1:0] oeRd, oeWr, rd;
  logic [3:0] divTab [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hC, 4'h0, 4'h1};
  int expG [3][NUM_CTR] = '{'{0, 0, 0, 4, 12}, '{12, 0, 12, 4, 12},
                            '{0, 0, 12, 4, 12}};
  // The wire: the device wins where it drives, else the host level.
  assign busLine = (~hostDataOe_n & hostDataOut) | (hostDataOe_n & hostLevel);

  tpio_host_model host (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN),
    .controlSel(controlSel), .hostLevel(hostLevel), .busLine(busLine));

  tpio_pin_io DUT (.clk(clk), .rst_n(rst_n), .sourcePins(sourcePins),
    .gatePins(gatePins), .csN(csN), .rdN(rdN), .wrN(wrN),
    .controlSel(controlSel), .hostDataIn(busLine),
    .hostDataOut(hostDataOut), .hostDataOe_n(hostDataOe_n),
    .ctrSrcSel(ctrSrcSel), .ctrSrcPol(ctrSrcPol), .ctrGateSel(ctrGateSel),
    .ctrGatePol(ctrGatePol), .ctrGateMode(ctrGateMode),
    .ctrOutMode(ctrOutMode), .ctrOutPol(ctrOutPol), .ctrLoad(ctrLoad),
    .ctrHold(ctrHold), .alarmEnable(alarmEnable), .alarmValue(alarmValue),
    .counterOutputs(counterOutputs),
    .counterOutputsOe_n(counterOutputsOe_n), .freqOut(freqOut),
    .commandCode(commandCode), .commandStrobe(), .dataPointer(dataPointer),
    .busWide(busWide));

  // Clock of 20 ns period.
  initial forever #10 clk = ~clk;
  // Line enables seen during reads and during writes.
  always @(negedge clk) begin
    if (!csN && !rdN) oeRd <= hostDataOe_n;
    if (!csN && !wrN) oeWr <= hostDataOe_n;
  end
  // Compare of a line, field or flag value.
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      nErrors++;
    end
  endtask : checkVal
  // Compare of an event count.
  task automatic checkCnt(input int got, input int exp);
    numChecks++;
    if (got != exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      nErrors++;
    end
  endtask : checkCnt
  // Master mode write; narrow mode sends low byte then high byte.
  task automatic setMaster(input logic [15:0] v);
    host.busWrite(1'b1, 16'h0000);
    if (host.narrow) begin
      host.busWrite(1'b0, {8'h00, v[7:0]});
      host.busWrite(1'b0, {8'h00, v[15:8]});
    end else begin
      host.busWrite(1'b0, v);
    end
  endtask : setMaster
  // Lets old divider phase drain, then counts over n cycles.
  task automatic countWin(input int n);
    logic [NUM_CTR-1:0] prev;
    repeat (20) @(negedge clk);
    foutCnt = 0;
    outCnt = '{default: 0};
    prev = counterOutputs;
    repeat (n) begin
      @(negedge clk);
      if (freqOut === 1'b1) foutCnt++;
      for (int i = 0; i < NUM_CTR; i++) begin
        if (counterOutputs[i] === 1'b1 && prev[i] !== 1'b1) outCnt[i]++;
      end
      prev = counterOutputs;
    end
  endtask : countWin
  // Four clean pulses on the pin that a source code names.
  task automatic pulsePins(input int code);
    repeat (22) @(posedge clk);
    repeat (4) begin
      if (code < 10) sourcePins[code-5] <= 1'b1;
      else gatePins[code-10] <= 1'b1;
      repeat (4) @(posedge clk);
      sourcePins <= '0;
      gatePins <= '0;
      repeat (4) @(posedge clk);
    end
  endtask : pulsePins
  // Ends the run with the verdict.
  task automatic completeRun();
    if (nErrors == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : completeRun
  // Guard against a hang; the tests need about 1600 cycles.
  initial begin
    #(20 * 20000);
    nErrors++;
    completeRun();
  end
  // Main sequence.
  initial begin
    for (int i = 0; i < NUM_CTR; i++) begin
      ctrGateMode[i] = GATE_NONE;
      ctrOutMode[i] = OUT_PULSE;
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    checkVal(16'(busWide), 16'h0000);
    checkVal(16'(dataPointer), 16'h0000);
    checkVal(hostDataOe_n, 16'hFFFF);
    checkVal(16'(counterOutputs), 16'h0000);
    @(negedge clk);
    checkVal(16'(counterOutputs), 16'h0015);
    @(posedge clk);
    alarmEnable <= 2'h3;
    ctrOutMode[4] <= OUT_OFF;
    repeat (3) @(negedge clk);
    checkVal(16'(counterOutputs[1:0]), 16'h0002);
    checkVal(16'(counterOutputsOe_n), 16'h0010);
    @(posedge clk);
    alarmEnable <= 2'h0;
    countWin(48);
    checkCnt(foutCnt, 3);
    for (int k = 0; k < 8; k++) begin
      setMaster({12'h000, divTab[k]});
      countWin(48);
      checkCnt(foutCnt, 48 / (divTab[k] == 4'h0 ? 16 : int'(divTab[k])));
    end
    setMaster(16'h0011);
    countWin(48);
    checkCnt(foutCnt, 3);
    setMaster(16'h00F1);
    countWin(48);
    checkCnt(foutCnt, 0);
    foreach (expG[k]) begin
      setMaster({8'h00, 4'(5 + 4 * k + (k == 2 ? -3 : 0)), 4'h1});
      fork
        countWin(48);
        pulsePins(5 + 4 * k + (k == 2 ? -3 : 0));
      join
      checkCnt(foutCnt, 4);
    end
    setMaster(16'h1001);
    countWin(48);
    checkCnt(foutCnt, 0);
    checkVal(16'(freqOut), 16'h0000);
    setMaster(16'h10A5);
    host.busRead(1'b0, rd);
    checkVal({8'h00, rd[7:0]}, 16'h00A5);
    host.busRead(1'b0, rd);
    checkVal({8'h00, rd[7:0]}, 16'h0010);
    checkVal(oeRd, 16'hFF00);
    checkVal(oeWr, 16'hFFFF);
    host.busRead(1'b1, rd);
    checkVal({8'h00, rd[7:0]}, 16'h0015);
    @(posedge clk);
    ctrOutPol <= '0;
    for (int i = 0; i < NUM_CTR; i++) begin
      ctrSrcSel[i] <= 4'h0;
      ctrLoad[i] <= 16'h0004;
      ctrHold[i] <= 16'h0004;
      ctrOutMode[i] <= OUT_PULSE;
    end
    countWin(48);
    for (int i = 0; i < NUM_CTR; i++) checkCnt(outCnt[i], 12);
    @(posedge clk);
    ctrSrcSel[3] <= 4'h6;
    ctrLoad[3] <= 16'h0001;
    for (int i = 0; i < 3; i++) ctrGateMode[i] <= GATE_LEVEL;
    pulsePins(6);
    for (int r = 0; r < 3; r++) begin
      @(posedge clk);
      if (r == 1) ctrGatePol <= 5'h05;
      if (r == 2) host.upper <= 8'hFE;
      fork
        countWin(48);
        pulsePins(6);
      join
      for (int i = 0; i < NUM_CTR; i++) checkCnt(outCnt[i], expG[r][i]);
    end
    @(posedge clk);
    host.upper <= 8'hFF;
    // Toggle, duty, select and edge gating in one window.
    ctrGateMode[0] <= GATE_NONE;
    ctrGateMode[1] <= GATE_NONE;
    ctrGateMode[2] <= GATE_SELECT;
    ctrGateMode[3] <= GATE_EDGE;
    ctrGateSel[2] <= 3'h1;
    ctrSrcSel[3] <= 4'h0;
    ctrOutMode[0] <= OUT_TOGGLE;
    ctrOutMode[1] <= OUT_DUTY;
    ctrLoad[1] <= 16'h0002;
    ctrHold[1] <= 16'h0006;
    ctrHold[2] <= 16'h0002;
    ctrLoad[3] <= 16'h0004;
    fork
      countWin(48);
      pulsePins(10);
    join
    checkCnt(outCnt[0], 6);
    checkCnt(outCnt[1], 6);
    checkCnt(outCnt[2], 24);
    checkCnt(outCnt[3], 4);
    checkCnt(outCnt[4], 12);
    setMaster(16'h4000);
    checkVal(16'(busWide), 16'h0001);
    @(posedge clk);
    host.narrow <= 1'b0;
    host.busWrite(1'b1, 16'h00ED);
    checkVal(16'(commandCode), 16'h00ED);
    checkVal(16'(dataPointer), 16'h0005);
    setMaster(16'h50A5);
    host.busRead(1'b0, rd);
    checkVal(rd, 16'h50A5);
    checkVal(oeRd, 16'h0000);
    checkVal(hostDataOe_n, 16'hFFFF);
    completeRun();
  end
endmodule : test_tpio_pin_io

// File: tpio_counter_slice.sv
// One counter with its gating and its output waveform logic.
`timescale 1ns/100ps
module tpio_counter_slice #(
  parameter bit HAS_ALARM = 1'b0,
  parameter int CNT_W = tpio_pkg::CNT_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Selected count edge and gate level.
  input wire logic countTick,
  input wire logic gateLevel,
  input wire logic gatePol,
  input wire logic auxQualify,
  input wire logic reducedWidth,
  input wire tpio_pkg::tpio_gate_mode_type gateMode,
  // Reload values and output settings.
  input wire logic [CNT_W-1:0] loadValue,
  input wire logic [CNT_W-1:0] holdValue,
  input wire tpio_pkg::tpio_out_mode_type outMode,
  input wire logic outPol,
  input wire logic alarmEnable,
  input wire logic [CNT_W-1:0] alarmValue,
  // Counter contents and output pin.
  output logic [CNT_W-1:0] count,
  output logic outLevel,
  output logic outOe_n
);
  import tpio_pkg::*;

  // Whole state of the slice.
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic gatePrev;
    logic armed;
    logic phase;
    logic raw;
    logic outLevel;
    logic outOe_n;
  } tpio_slice_state_type;

  tpio_slice_state_type st, next_st;
  logic gateOk; // Gate active after polarity and qualifier.
  logic run; // Counting allowed this cycle.
  logic terminal; // Count would reach zero and reloads instead.
  logic alarmOn; // Alarm override in force.
  logic [CNT_W-1:0] reloadVal;

  assign alarmOn = HAS_ALARM & alarmEnable;
  assign count = st.count;
  assign outLevel = st.outLevel;
  assign outOe_n = st.outOe_n;

  // Next state: gating, count, reload and waveform.
  always_comb begin
    next_st = st;
    // A low qualifier in narrow bus mode blocks the gate.
    gateOk = (gateLevel ^ gatePol) & (~reducedWidth | auxQualify);
    next_st.gatePrev = gateOk;
    case (gateMode)
      GATE_NONE: run = 1'b1;
      GATE_LEVEL: run = gateOk;
      GATE_EDGE: run = st.armed | (gateOk & ~st.gatePrev);
      GATE_SELECT: run = 1'b1;
      default: run = 1'b0;
    endcase
    // Gate level picks between the two periods in select mode.
    if (gateMode == GATE_SELECT) begin
      reloadVal = gateOk ? holdValue : loadValue;
    end else if (outMode == OUT_DUTY) begin
      reloadVal = st.phase ? loadValue : holdValue;
    end else begin
      reloadVal = loadValue;
    end
    // Zero is never held: a count of one or zero reloads instead.
    terminal = countTick & run & (st.count[CNT_W-1:1] == '0);
    if (countTick & run) begin
      next_st.count = terminal ? reloadVal : st.count - 1'b1;
    end
    if (gateMode == GATE_EDGE) begin
      next_st.armed = run & ~terminal;
    end
    if (terminal) begin
      next_st.phase = ~st.phase;
    end
    case (outMode)
      OUT_PULSE: next_st.raw = terminal;
      OUT_TOGGLE: next_st.raw = st.raw ^ terminal;
      OUT_DUTY: next_st.raw = next_st.phase;
      OUT_OFF: next_st.raw = 1'b0;
      default: next_st.raw = 1'b0;
    endcase
    // The alarm match overrides the normal waveform.
    if (alarmOn) begin
      next_st.outLevel = (st.count == alarmValue) ^ outPol;
    end else begin
      next_st.outLevel = next_st.raw ^ outPol;
    end
    next_st.outOe_n = (outMode == OUT_OFF);
  end

  // State register; reset leaves the output enabled and low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tc_pulse: assert property (
    (countTick && run && st.count == 1 && outMode == OUT_PULSE && !alarmOn)
    |=> (outLevel != $past(outPol)))
    else $error("Terminal count gave no output pulse.");
  chk_alarm_match: assert property (
    (alarmOn && st.count == alarmValue) |=> (outLevel != $past(outPol)))
    else $error("Alarm match did not assert the output.");
  chk_level_hold: assert property (
    (gateMode == GATE_LEVEL && !gateOk) |=> (st.count == $past(st.count)))
    else $error("Counter moved while level gate was inactive.");
  chk_output_release: assert property (
    (outMode == OUT_OFF) |=> outOe_n)
    else $error("Output driven in three-state mode.");
endmodule : tpio_counter_slice

// File: tpio_host_model.sv
// Host processor model that drives the timer bus strobes and lines.
`timescale 1ns/100ps
module tpio_host_model (
  // Clock.
  input wire logic clk,
  // Strobes and the level the host puts on the lines.
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic controlSel,
  output logic [15:0] hostLevel,
  // Resolved line levels.
  input wire logic [15:0] busLine
);
  // Idle cycles after each access; a larger value models a slow host.
  int gap = 0;
  // Narrow mode: upper lines carry the gate qualifiers.
  logic narrow = 1'b1;
  logic [7:0] upper = 8'hFF;
  logic [15:0] drive = 16'h0000;
  // Qualifiers stay steady in narrow mode, even between accesses.
  assign hostLevel = narrow ? {upper, drive[7:0]} : drive;
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    controlSel = 1'b0;
  end
  // One write; the write strobe is never raised with the read strobe.
  task automatic busWrite(input logic ctl, input logic [15:0] val);
    @(posedge clk);
    csN <= 1'b0;
    wrN <= 1'b0;
    controlSel <= ctl;
    drive <= val;
    @(posedge clk);
    csN <= 1'b1;
    wrN <= 1'b1;
    // Released lines show the inverse so stale data never looks valid.
    drive <= ~val;
    repeat (gap + 1) @(posedge clk);
  endtask : busWrite
  // One read; data is taken mid-cycle, where the read word has settled.
  task automatic busRead(input logic ctl, output logic [15:0] val);
    @(posedge clk);
    csN <= 1'b0;
    rdN <= 1'b0;
    controlSel <= ctl;
    @(posedge clk);
    @(negedge clk);
    val = busLine;
    @(posedge clk);
    csN <= 1'b1;
    rdN <= 1'b1;
    repeat (gap + 1) @(posedge clk);
  endtask : busRead
endmodule : tpio_host_model

// File: tpio_pin_io.sv
// Pin level logic of the five counter timing controller.
`timescale 1ns/100ps
// How it works
// - Frequency-out divider divides by 1 to 16
// - Divider input picked from fifteen sources
// - Frequency-out switchable; low while off
// - Reset selects first tap, divides by 16
// - One gate pin may gate all five counters
// - Gate pins usable as count sources everywhere
// - Gate polarity set per counter
// - Level, edge, select and no gating modes
// - Narrow bus adds auxiliary gate qualifier
// - Low qualifier line blocks the counter's gate
// - Any source pin, per-counter source polarity
// - Three-state outputs: pulse, square, duty, polarity
// - Waveform made from would-be-zero count event
// - Counters 1 and 2 alarm match output
// - High level on data line means one
// - Lines input on write, output on read
// - Lines released while chip select inactive
// - Bus starts 8-bit; mode bit widens it
// - Control selects command, pointer and status
module tpio_pin_io (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // External count and gate pins.
  input wire logic [tpio_pkg::NUM_PINS-1:0] sourcePins,
  input wire logic [tpio_pkg::NUM_PINS-1:0] gatePins,
  // Host bus strobes and data lines.
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic controlSel,
  input wire logic [tpio_pkg::DATA_W-1:0] hostDataIn,
  output logic [tpio_pkg::DATA_W-1:0] hostDataOut,
  output logic [tpio_pkg::DATA_W-1:0] hostDataOe_n,
  // Per-counter configuration.
  input wire logic [tpio_pkg::NUM_CTR-1:0][tpio_pkg::SEL_W-1:0] ctrSrcSel,
  input wire logic [tpio_pkg::NUM_CTR-1:0] ctrSrcPol,
  input wire logic [tpio_pkg::NUM_CTR-1:0][tpio_pkg::GSEL_W-1:0] ctrGateSel,
  input wire logic [tpio_pkg::NUM_CTR-1:0] ctrGatePol,
  input wire tpio_pkg::tpio_gate_mode_type [tpio_pkg::NUM_CTR-1:0] ctrGateMode,
  input wire tpio_pkg::tpio_out_mode_type [tpio_pkg::NUM_CTR-1:0] ctrOutMode,
  input wire logic [tpio_pkg::NUM_CTR-1:0] ctrOutPol,
  input wire logic [tpio_pkg::NUM_CTR-1:0][tpio_pkg::CNT_W-1:0] ctrLoad,
  input wire logic [tpio_pkg::NUM_CTR-1:0][tpio_pkg::CNT_W-1:0] ctrHold,
  input wire logic [1:0] alarmEnable,
  input wire logic [1:0][tpio_pkg::CNT_W-1:0] alarmValue,
  // Counter and frequency outputs.
  output logic [tpio_pkg::NUM_CTR-1:0] counterOutputs,
  output logic [tpio_pkg::NUM_CTR-1:0] counterOutputsOe_n,
  output logic freqOut,
  // Command port and mode status.
  output logic [tpio_pkg::BYTE_W-1:0] commandCode,
  output logic commandStrobe,
  output logic [tpio_pkg::PTR_W-1:0] dataPointer,
  output logic busWide
);
  import tpio_pkg::*;

  // Whole state of the top level.
  typedef struct packed {
    logic [PRESCALE_W-1:0] prescale;
    logic [2*NUM_PINS-1:0] pinPrev;
    logic [FREQ_OUT_DIV_W-1:0] foutCount;
    logic freqOut;
    logic [DATA_W-1:0] masterMode;
    logic [BYTE_W-1:0] command;
    logic [PTR_W-1:0] dataPointer;
    logic [BYTE_W-1:0] lowByte;
    logic byteHigh;
    logic wrPrev;
    logic rdPrev;
    logic commandStrobe;
    logic [DATA_W-1:0] readData;
    logic [4:0] mmStable;
  } tpio_main_state_type;

  tpio_main_state_type st, next_st;
  logic [NUM_TAPS-1:0] taps; // One-cycle enables of the scaled clocks.
  logic [2*NUM_PINS-1:0] pinNow; // Gate pins above source pins.
  logic [2*NUM_PINS-1:0] pinRise;
  logic [2*NUM_PINS-1:0] pinFall;
  logic [NUM_CTR-1:0] ctrTick; // Selected active source edge.
  logic [NUM_CTR-1:0] ctrGate; // Selected raw gate level.
  logic [NUM_CTR-1:0][CNT_W-1:0] ctrCount;
  logic csAct; // Chip select active.
  logic rdAct; // Read strobe qualified by chip select.
  logic wrAct; // Write strobe qualified by chip select.
  logic wide; // Sixteen bit bus mode.
  logic foutTick; // Selected divider input edge.
  logic [FREQ_OUT_DIV_W-1:0] divLast; // Last count of one divider period.

  // Pick one of the fifteen sources; the unused code gives nothing.
  function automatic logic pickTick(input logic [NUM_SOURCES-1:0] ticks,
                                    input logic [SEL_W-1:0] sel);
    pickTick = (sel == SEL_NONE) ? 1'b0 : ticks[sel];
  endfunction : pickTick

  assign pinNow = {gatePins, sourcePins};
  assign pinRise = pinNow & ~st.pinPrev;
  assign pinFall = ~pinNow & st.pinPrev;
  assign csAct = ~csN;
  assign rdAct = csAct & ~rdN;
  assign wrAct = csAct & ~wrN;
  assign wide = st.masterMode[MM_BUS_WIDTH];

  // Scaled clock taps: each is the previous one divided by sixteen.
  always_comb begin
    taps[0] = 1'b1;
    for (int k = 1; k < NUM_TAPS; k++) begin
      // Tap k fires when the low k steps of the prescaler are all ones.
      taps[k] = &(st.prescale |
                  ~PRESCALE_W'((32'h1 << (k * TAP_STEP_BITS)) - 32'h1));
    end
  end

  // Source and gate routing for every counter.
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      // Polarity decides which edge of a pin counts; taps ignore it.
      ctrTick[i] = pickTick(ctrSrcPol[i] ? {pinFall, taps} :
                            {pinRise, taps}, ctrSrcSel[i]);
      // Any gate pin may serve several counters at once.
      ctrGate[i] = (ctrGateSel[i] < GSEL_W'(NUM_PINS)) ?
                   gatePins[ctrGateSel[i]] : 1'b0;
    end
  end

  // Divider input comes from the same fifteen sources as the counters.
  assign foutTick = pickTick({pinRise, taps},
                             st.masterMode[MM_SEL_LSB +: SEL_W]);
  // Field value zero means sixteen, so the minus one wraps to fifteen.
  assign divLast = st.masterMode[MM_DIV_LSB +: FREQ_OUT_DIV_W] - 1'b1;

  // Next state of the prescaler, divider and host port.
  always_comb begin
    next_st = st;
    next_st.prescale = st.prescale + 1'b1;
    next_st.pinPrev = pinNow;
    next_st.commandStrobe = 1'b0;
    next_st.wrPrev = wrAct;
    next_st.rdPrev = rdAct;
    // The divider runs while off, so it comes back in step.
    if (foutTick) begin
      next_st.foutCount = (st.foutCount == divLast) ? '0 :
                          st.foutCount + 1'b1;
    end
    next_st.freqOut = foutTick & (st.foutCount == divLast) &
                      ~st.masterMode[MM_FREQ_OUT_OFF];
    // A write is taken once, on the first cycle of its strobe.
    if (wrAct & ~st.wrPrev) begin
      if (controlSel) begin
        next_st.command = hostDataIn[BYTE_W-1:0];
        next_st.dataPointer = hostDataIn[PTR_W-1:0];
        next_st.commandStrobe = 1'b1;
        next_st.byteHigh = 1'b0;
      end else if (wide) begin
        if (st.dataPointer == PTR_MASTER) begin
          next_st.masterMode = hostDataIn;
        end
      end else if (!st.byteHigh) begin
        // Narrow bus: low byte first, held until its partner.
        next_st.lowByte = hostDataIn[BYTE_W-1:0];
        next_st.byteHigh = 1'b1;
      end else begin
        if (st.dataPointer == PTR_MASTER) begin
          next_st.masterMode = {hostDataIn[BYTE_W-1:0], st.lowByte};
        end
        next_st.byteHigh = 1'b0;
      end
    end
    // A narrow data read steps to the other byte when it ends.
    if (~rdAct & st.rdPrev & ~controlSel & ~wide) begin
      next_st.byteHigh = ~st.byteHigh;
    end
    // Read word: status on control, else the pointed register.
    if (controlSel) begin
      next_st.readData = {{(DATA_W-NUM_CTR){1'b0}}, counterOutputs};
    end else if (st.dataPointer == PTR_MASTER) begin
      next_st.readData = st.masterMode;
    end else if (st.dataPointer - PTR_CTR_BASE < PTR_W'(NUM_CTR)) begin
      next_st.readData = ctrCount[st.dataPointer - PTR_CTR_BASE];
    end else begin
      next_st.readData = '0;
    end
    if (!wide) begin
      next_st.readData = {{BYTE_W{1'b0}}, st.byteHigh ?
                          next_st.readData[DATA_W-1:BYTE_W] :
                          next_st.readData[BYTE_W-1:0]};
    end
    // Helper: cycles since the master mode last changed.
    if (next_st.masterMode != st.masterMode) begin
      next_st.mmStable = '0;
    end else if (st.mmStable != STABLE_MAX) begin
      next_st.mmStable = st.mmStable + 1'b1;
    end
  end

  // State register; reset leaves the master mode at its default.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Drive the data lines only during a read; upper half only when wide.
  // Write wins if the host breaks the exclusive strobe convention.
  assign hostDataOe_n[BYTE_W-1:0] = {BYTE_W{~(rdAct & ~wrAct)}};
  assign hostDataOe_n[DATA_W-1:BYTE_W] =
    {(DATA_W-BYTE_W){~(rdAct & ~wrAct & wide)}};
  assign hostDataOut = st.readData;
  assign freqOut = st.freqOut;
  assign commandCode = st.command;
  assign commandStrobe = st.commandStrobe;
  assign dataPointer = st.dataPointer;
  assign busWide = wide;

  // The five counters; only the first two carry an alarm comparator.
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    tpio_counter_slice #(
      .HAS_ALARM(i < 2),
      .CNT_W(CNT_W)
    ) u_slice (
      .clk(clk),
      .rst_n(rst_n),
      .countTick(ctrTick[i]),
      .gateLevel(ctrGate[i]),
      .gatePol(ctrGatePol[i]),
      .auxQualify(hostDataIn[BYTE_W+i]),
      .reducedWidth(~wide),
      .gateMode(ctrGateMode[i]),
      .loadValue(ctrLoad[i]),
      .holdValue(ctrHold[i]),
      .outMode(ctrOutMode[i]),
      .outPol(ctrOutPol[i]),
      .alarmEnable((i < 2) ? alarmEnable[i % 2] : 1'b0),
      .alarmValue(alarmValue[i % 2]),
      .count(ctrCount[i]),
      .outLevel(counterOutputs[i]),
      .outOe_n(counterOutputsOe_n[i])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A pulse at the reset setting is followed by eight quiet cycles.
  sequence s_freq_out_quiet;
    !freqOut [*8];
  endsequence
  sequence s_freq_out_reset_pulse;
    freqOut && st.masterMode == MM_RESET_VALUE;
  endsequence

  chk_freq_out_quiet: assert property (
    s_freq_out_reset_pulse ##1 (st.masterMode == MM_RESET_VALUE) |-> s_freq_out_quiet)
    else $error("Frequency out pulsed too soon.");
  chk_freq_out_period: assert property (
    (st.masterMode == MM_RESET_VALUE && st.mmStable == STABLE_MAX &&
     $past(freqOut, 16)) |-> freqOut)
    else $error("Frequency out period is not sixteen.");
  chk_freq_out_off: assert property (
    st.masterMode[MM_FREQ_OUT_OFF] |=> !freqOut)
    else $error("Frequency out high while switched off.");
  chk_bus_release: assert property (
    csN |-> (hostDataOe_n == '1))
    else $error("Data lines driven without chip select.");
  chk_narrow_upper: assert property (
    !wide |-> (hostDataOe_n[DATA_W-1:BYTE_W] == '1))
    else $error("Upper data lines driven in narrow mode.");
  chk_read_drive: assert property (
    (!csN && !rdN && wrN) |-> (hostDataOe_n[BYTE_W-1:0] == '0))
    else $error("Data lines not driven during a read.");
  chk_pointer_load: assert property (
    (wrAct && !st.wrPrev && controlSel) |=>
    (dataPointer == $past(hostDataIn[PTR_W-1:0]) && commandStrobe))
    else $error("Control write did not load the pointer.");
endmodule : tpio_pin_io

// File: tpio_pkg.sv
// Shared constants and types for the timing controller pin block.
package tpio_pkg;
  // Block dimensions.
  localparam int NUM_CTR = 5;
  localparam int NUM_PINS = 5;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int FREQ_OUT_DIV_W = 4;
  localparam int SEL_W = 4;
  localparam int GSEL_W = 3;
  localparam int PTR_W = 3;
  // Source select codes: taps 0..4, source pins 5..9, gate pins 10..14.
  localparam int NUM_TAPS = 5;
  localparam int NUM_SOURCES = 15;
  localparam logic [SEL_W-1:0] SEL_NONE = 4'hF;
  // Each tap is the previous one divided by two to this power.
  localparam int TAP_STEP_BITS = 4;
  localparam int PRESCALE_W = 16;
  // Master mode fields.
  localparam int MM_DIV_LSB = 0;
  localparam int MM_SEL_LSB = 4;
  localparam int MM_FREQ_OUT_OFF = 12;
  localparam int MM_BUS_WIDTH = 14;
  localparam logic [DATA_W-1:0] MM_RESET_VALUE = 16'h0000;
  // Data pointer codes; counters follow the master mode code.
  localparam logic [PTR_W-1:0] PTR_MASTER = 3'h0;
  localparam logic [PTR_W-1:0] PTR_CTR_BASE = 3'h1;
  // Frequency-out period after reset, in clock cycles.
  localparam int FREQ_OUT_RESET_PERIOD = 16;
  localparam logic [4:0] STABLE_MAX = 5'h1F;
  // Gating and output modes.
  typedef enum logic [1:0] {
    GATE_NONE, GATE_LEVEL, GATE_EDGE, GATE_SELECT
  } tpio_gate_mode_type;
  typedef enum logic [1:0] {
    OUT_PULSE, OUT_TOGGLE, OUT_DUTY, OUT_OFF
  } tpio_out_mode_type;
endpackage : tpio_pkg
